// >>> src/tmoc_pkg.sv
package tmoc_pkg;

  localparam int TMOC_NUM = 2;
  localparam int TMOC_PINS = 4;
  localparam int TMOC_PRESC_W = 7;
  localparam int TMOC_RUN_START = 2;

  localparam logic [31:0] TMOC_RUN_IDX [TMOC_NUM] = '{32'hfffff540, 32'hfffff610};
  localparam logic [31:0] TMOC_MODE_IDX [TMOC_NUM] = '{32'h0ffff541, 32'hfffff611};
  localparam logic [31:0] TMOC_OUT_IDX [TMOC_NUM] = '{32'h0ffff542, 32'hfffff612};
  localparam logic [31:0] TMOC_EDGE_IDX [TMOC_NUM] = '{32'hfffff544, 32'hfffff614};
  localparam logic [31:0] TMOC_STAT_IDX [TMOC_NUM] = '{32'hfffff5f0, 32'hfffff6f0};

  localparam logic [2:0] TMOC_K_RUN = 3'h0;
  localparam logic [2:0] TMOC_K_MODE = 3'h1;
  localparam logic [2:0] TMOC_K_OUT = 3'h2;
  localparam logic [2:0] TMOC_K_EDGE = 3'h3;
  localparam logic [2:0] TMOC_K_STAT = 3'h4;

  localparam logic [7:0] TMOC_REG_RESET = 8'h00;
  localparam logic [7:0] TMOC_RUN_WMASK = 8'h87;
  localparam logic [7:0] TMOC_MODE_WMASK = 8'ha7;
  localparam logic [7:0] TMOC_EDGE_WMASK = 8'h0f;
  localparam logic [7:0] TMOC_OUT_WMASK = 8'hff;
  localparam logic [23:0] TMOC_RD_PAD = 24'h000000;

  localparam int TMOC_RUN_BIT = 7;
  localparam int TMOC_CKS_LSB = 0;
  localparam int TMOC_SYNC_BIT = 7;
  localparam int TMOC_TRIG_BIT = 6;
  localparam int TMOC_CLKSRC_BIT = 5;
  localparam int TMOC_MODE_LSB = 0;
  localparam int TMOC_EES_LSB = 2;
  localparam int TMOC_ETS_LSB = 0;

  typedef enum logic [7:0] {
    TMOC_INTERVAL = 8'h01,
    TMOC_EVENT = 8'h02,
    TMOC_EXTTRIG = 8'h04,
    TMOC_ONESHOT = 8'h08,
    TMOC_PWM = 8'h10,
    TMOC_FREERUN = 8'h20,
    TMOC_PWIDTH = 8'h40,
    TMOC_TRIPWM = 8'h80
  } tmoc_mode_type;

  typedef struct packed {
    logic [TMOC_PINS-1:0] level;
    logic [TMOC_PINS-1:0] enable;
  } tmoc_outctl_type;

  typedef struct packed {
    logic hit;
    logic inst;
    logic [2:0] kind;
  } tmoc_sel_type;

  function automatic tmoc_mode_type tmoc_decode_mode(input logic [2:0] f);
    case (f)
      3'h0: return TMOC_INTERVAL;
      3'h1: return TMOC_EVENT;
      3'h2: return TMOC_EXTTRIG;
      3'h3: return TMOC_ONESHOT;
      3'h4: return TMOC_PWM;
      3'h5: return TMOC_FREERUN;
      3'h6: return TMOC_PWIDTH;
      default: return TMOC_TRIPWM;
    endcase
  endfunction : tmoc_decode_mode

  function automatic logic tmoc_edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    case (sel)
      2'h1: return ~prev & cur;
      2'h2: return prev & ~cur;
      2'h3: return prev ^ cur;
      default: return 1'b0;
    endcase
  endfunction : tmoc_edge_hit

  function automatic logic tmoc_idx_hit(input logic [31:0] addr, input logic [31:0] idx);
    return (addr[31:2] == idx[29:0]) && (addr[1:0] == 2'h0);
  endfunction : tmoc_idx_hit

endpackage : tmoc_pkg

// >>> src/tmoc_outstage.sv
`timescale 1ns/1ps
module tmoc_outstage #(
  parameter int PINS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tmoc_pkg::tmoc_outctl_type ctl_i,
  input wire logic [PINS-1:0] pulse_i,
  input wire logic running_i,
  output logic [PINS-1:0] pin_o
);
  import tmoc_pkg::*;

  logic [PINS-1:0] next_pin;

  if (PINS != TMOC_PINS) begin : g_bad_pins
    $error("tmoc_outstage: pin count must match the control field width");
  end

  // A stopped timer makes no pulses, so a disabled or stopped pin rests at its level bit.
  always_comb begin
    for (int m = 0; m < PINS; m++) begin
      if (ctl_i.enable[m]) begin
        next_pin[m] = (pulse_i[m] & running_i) ^ ctl_i.level[m];
      end else begin
        next_pin[m] = ctl_i.level[m];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= '0;
    end else begin
      pin_o <= next_pin;
    end
  end

endmodule : tmoc_outstage

// >>> src/tmoc_top.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - Mode codes 000 interval, 001 event counter, 010 trigger pulse, 011 one-shot.
// - Mode codes 100 PWM, 101 free-running, 110 width measure, 111 triangular PWM.
// - Reset clears mode and output control registers of both timers to zero.
// - Control registers accept whole-byte and single-bit read and write.
// - Sync bit clear runs independently; set makes timer 1 follow timer 0.
// - Writing trigger bit while running fires one-shot or trigger-pulse mode only.
// - Trigger bit always reads zero.
// - Unless slaved, clock source 0 counts prescaled clock except in event counter mode; 1 counts chosen edges on the timer's own external pin.
// - Level bit 0 keeps output polarity, 1 inverts it.
// - Disabled output rests at its level bit; enabled output carries pulses.
// - Run bit clear stops and resets timer; set restarts within two clocks.
// - Count clock is peripheral clock divided by two to the prescaler field.
// - Event edge codes 00 none, 01 rising, 10 falling, 11 both.
module tmoc_top #(
  parameter int NUM = tmoc_pkg::TMOC_NUM,
  parameter int PRESC_W = tmoc_pkg::TMOC_PRESC_W
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O,
  input wire logic [NUM-1:0] EXT_PIN_I,
  input wire logic [NUM*tmoc_pkg::TMOC_PINS-1:0] PULSE_I,
  output logic [NUM*tmoc_pkg::TMOC_PINS-1:0] TIMER_OUT_O,
  output logic [NUM-1:0] COUNT_TICK_O,
  output logic [NUM-1:0] TRIGGER_O,
  output logic [NUM-1:0] RUNNING_O,
  output logic [NUM-1:0] SLAVE_O,
  output logic [NUM*8-1:0] MODE_O
);
  import tmoc_pkg::*;

  if (NUM != TMOC_NUM) begin : g_bad_num
    $error("tmoc_top: the register map serves exactly two timers");
  end
  if (PRESC_W < TMOC_PRESC_W) begin : g_bad_presc
    $error("tmoc_top: prescaler counter too narrow for divide by 128");
  end

  logic pready;
  logic next_pready;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic pslverr;
  logic next_pslverr;
  logic setup;
  logic wr_go;
  tmoc_sel_type sel;
  logic [7:0] rd_byte;

  logic [7:0] run_reg [NUM];
  logic [7:0] mode_reg [NUM];
  logic [7:0] out_reg [NUM];
  logic [7:0] edge_reg [NUM];
  logic [7:0] next_run_reg [NUM];
  logic [7:0] next_mode_reg [NUM];
  logic [7:0] next_out_reg [NUM];
  logic [7:0] next_edge_reg [NUM];
  logic [NUM-1:0] trig_req;
  logic [7:0] stat_byte [NUM];
  logic [NUM-1:0] tick_raw;

  assign PREADY_O = pready;
  assign PRDATA_O = prdata;
  assign PSLVERR_O = pslverr;

  // Address decode over every mapped register of both timers.
  always_comb begin
    sel = '0;
    for (int i = 0; i < NUM; i++) begin
      if (tmoc_idx_hit(PADDR_I, TMOC_RUN_IDX[i])) begin
        sel = '{hit: 1'b1, inst: i[0], kind: TMOC_K_RUN};
      end
      if (tmoc_idx_hit(PADDR_I, TMOC_MODE_IDX[i])) begin
        sel = '{hit: 1'b1, inst: i[0], kind: TMOC_K_MODE};
      end
      if (tmoc_idx_hit(PADDR_I, TMOC_OUT_IDX[i])) begin
        sel = '{hit: 1'b1, inst: i[0], kind: TMOC_K_OUT};
      end
      if (tmoc_idx_hit(PADDR_I, TMOC_EDGE_IDX[i])) begin
        sel = '{hit: 1'b1, inst: i[0], kind: TMOC_K_EDGE};
      end
      if (tmoc_idx_hit(PADDR_I, TMOC_STAT_IDX[i])) begin
        sel = '{hit: 1'b1, inst: i[0], kind: TMOC_K_STAT};
      end
    end
  end

  // The trigger bit is never stored, so it reads zero on its own.
  always_comb begin
    case (sel.kind)
      TMOC_K_RUN: rd_byte = run_reg[sel.inst];
      TMOC_K_MODE: rd_byte = mode_reg[sel.inst];
      TMOC_K_OUT: rd_byte = out_reg[sel.inst];
      TMOC_K_EDGE: rd_byte = edge_reg[sel.inst];
      TMOC_K_STAT: rd_byte = stat_byte[sel.inst];
      default: rd_byte = TMOC_REG_RESET;
    endcase
  end

  // One fixed access cycle: ready rises in the first access cycle after setup.
  always_comb begin
    setup = PSEL_I & ~PENABLE_I;
    wr_go = PSEL_I & PENABLE_I & pready & PWRITE_I;
    next_pready = setup & ~pready;
    next_pslverr = setup & ~sel.hit;
    next_prdata = 32'h00000000;
    if (setup & ~PWRITE_I & sel.hit) begin
      next_prdata = {TMOC_RD_PAD, rd_byte};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Bit operations arrive as byte writes on lane 0; the upper lanes hold no bits.
  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      next_run_reg[i] = run_reg[i];
      next_mode_reg[i] = mode_reg[i];
      next_out_reg[i] = out_reg[i];
      next_edge_reg[i] = edge_reg[i];
      trig_req[i] = 1'b0;
      if (wr_go & sel.hit & PSTRB_I[0] & (sel.inst == i[0])) begin
        case (sel.kind)
          TMOC_K_RUN: next_run_reg[i] = PWDATA_I[7:0] & TMOC_RUN_WMASK;
          TMOC_K_MODE: begin
            next_mode_reg[i] = PWDATA_I[7:0] & TMOC_MODE_WMASK;
            trig_req[i] = PWDATA_I[TMOC_TRIG_BIT];
          end
          TMOC_K_OUT: next_out_reg[i] = PWDATA_I[7:0] & TMOC_OUT_WMASK;
          TMOC_K_EDGE: next_edge_reg[i] = PWDATA_I[7:0] & TMOC_EDGE_WMASK;
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    for (int i = 0; i < NUM; i++) begin
      if (RST_I) begin
        run_reg[i] <= TMOC_REG_RESET;
        mode_reg[i] <= TMOC_REG_RESET;
        out_reg[i] <= TMOC_REG_RESET;
        edge_reg[i] <= TMOC_REG_RESET;
      end else begin
        run_reg[i] <= next_run_reg[i];
        mode_reg[i] <= next_mode_reg[i];
        out_reg[i] <= next_out_reg[i];
        edge_reg[i] <= next_edge_reg[i];
      end
    end
  end

  for (genvar g = 0; g < NUM; g++) begin : g_tm
    logic run;
    logic [TMOC_RUN_START-1:0] run_dly;
    logic [TMOC_RUN_START-1:0] next_run_dly;
    logic clk_on;
    logic [PRESC_W-1:0] presc;
    logic [PRESC_W-1:0] next_presc;
    logic [PRESC_W-1:0] mask;
    logic int_tick;
    logic ext_q;
    logic ext_prev;
    logic event_hit;
    logic ext_trig_hit;
    logic slave;
    logic trig_mode;
    tmoc_mode_type mode;
    logic tick;
    logic next_tick;
    logic trig;
    logic next_trig;
    logic [TMOC_PINS-1:0] pins;
    tmoc_outctl_type octl;

    assign run = run_reg[g][TMOC_RUN_BIT];
    assign clk_on = run_dly[TMOC_RUN_START-1];
    assign mode = tmoc_decode_mode(mode_reg[g][TMOC_MODE_LSB +: 3]);
    assign trig_mode = (mode == TMOC_EXTTRIG) || (mode == TMOC_ONESHOT);
    // Timer 0 has no master, so its sync bit cannot make it a slave.
    assign slave = (g != 0) && mode_reg[g][TMOC_SYNC_BIT];

    // A cleared run bit empties the delay line at once, which stops and resets the timer.
    always_comb begin
      if (run) begin
        next_run_dly = {run_dly[TMOC_RUN_START-2:0], 1'b1};
      end else begin
        next_run_dly = '0;
      end
      if (clk_on) begin
        next_presc = PRESC_W'(presc + 1'b1);
      end else begin
        next_presc = '0;
      end
    end

    // Divide by two to the field value; a zero field ticks every clock.
    always_comb begin
      mask = ~({PRESC_W{1'b1}} << run_reg[g][TMOC_CKS_LSB +: 3]);
      int_tick = clk_on && ((presc & mask) == mask);
      event_hit = tmoc_edge_hit(edge_reg[g][TMOC_EES_LSB +: 2], ext_prev, ext_q);
      ext_trig_hit = tmoc_edge_hit(edge_reg[g][TMOC_ETS_LSB +: 2], ext_prev, ext_q);
    end

    // The slave takes the master's raw tick so both counters step on the same edge.
    always_comb begin
      if (!clk_on) begin
        tick_raw[g] = 1'b0;
      end else if (slave) begin
        tick_raw[g] = tick_raw[0];
      end else if (mode_reg[g][TMOC_CLKSRC_BIT] || (mode == TMOC_EVENT)) begin
        tick_raw[g] = event_hit;
      end else begin
        tick_raw[g] = int_tick;
      end
      next_tick = tick_raw[g];
      next_trig = trig_mode & run & (trig_req[g] | (clk_on & ext_trig_hit));
    end

    always_ff @(posedge CLK_I) begin
      if (RST_I) begin
        run_dly <= '0;
        presc <= '0;
        ext_q <= 1'b0;
        ext_prev <= 1'b0;
        tick <= 1'b0;
        trig <= 1'b0;
      end else begin
        run_dly <= next_run_dly;
        presc <= next_presc;
        ext_q <= EXT_PIN_I[g];
        ext_prev <= ext_q;
        tick <= next_tick;
        trig <= next_trig;
      end
    end

    assign octl.level = {out_reg[g][7], out_reg[g][5], out_reg[g][3], out_reg[g][1]};
    assign octl.enable = {out_reg[g][6], out_reg[g][4], out_reg[g][2], out_reg[g][0]};

    tmoc_outstage #(
      .PINS(TMOC_PINS)
    ) u_out (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .ctl_i(octl),
      .pulse_i(PULSE_I[g*TMOC_PINS +: TMOC_PINS]),
      .running_i(clk_on),
      .pin_o(pins)
    );

    assign stat_byte[g] = {pins, 1'b0, ext_q, slave, clk_on};
    assign TIMER_OUT_O[g*TMOC_PINS +: TMOC_PINS] = pins;
    assign COUNT_TICK_O[g] = tick;
    assign TRIGGER_O[g] = trig;
    assign RUNNING_O[g] = clk_on;
    assign SLAVE_O[g] = mode_reg[g][TMOC_SYNC_BIT] && (g != 0);
    assign MODE_O[g*8 +: 8] = mode_reg[g];
  end

endmodule : tmoc_top

// >>> testbench/tmoc_properties.sv
`timescale 1ns/1ps
module tmoc_properties
  import tmoc_pkg::*;
#(
  parameter int NUM = 2
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic [31:0] PRDATA_O,
  input wire logic PSLVERR_O,
  input wire logic [NUM-1:0] COUNT_TICK_O,
  input wire logic [NUM-1:0] TRIGGER_O,
  input wire logic [NUM-1:0] RUNNING_O,
  input wire logic [NUM-1:0] SLAVE_O,
  input wire logic [NUM*8-1:0] MODE_O,
  input wire logic [NUM*tmoc_pkg::TMOC_PINS-1:0] TIMER_OUT_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  answer_time_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("no answer after setup");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O) else $error("ready held too long");
  rdata_lane_a: assert property (PRDATA_O[31:8] == 24'h000000 && (PREADY_O && !PSLVERR_O || PRDATA_O == 32'h00000000))
    else $error("read data outside its slot");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
  reset_clear_a: assert property ($fell(RST_I) |-> MODE_O == '0 && RUNNING_O == '0 && TIMER_OUT_O == '0)
    else $error("state not cleared by reset");
  fixed_bits_a: assert property (MODE_O[4:3] == 2'h0 && MODE_O[12:11] == 2'h0) else $error("fixed mode bits set");
  slave_map_a: assert property (!SLAVE_O[0] && SLAVE_O[1] == MODE_O[15]) else $error("slave flag wrong");
  trig_mode_a: assert property (TRIGGER_O[0] |-> $past(MODE_O[2:1]) == 2'h1) else $error("trigger in wrong mode");
  tick_idle_a: assert property (!RUNNING_O[0] && $past(!RUNNING_O[0]) |-> !COUNT_TICK_O[0])
    else $error("tick while stopped");
  slave_tick_a: assert property (SLAVE_O[1] && RUNNING_O[1] && $past(SLAVE_O[1] && RUNNING_O[1]) |->
    COUNT_TICK_O[1] == COUNT_TICK_O[0])
    else $error("slave tick differs");

  cover property (PSLVERR_O);
  cover property (TRIGGER_O[0]);
  cover property (SLAVE_O[1] && COUNT_TICK_O[1]);
endmodule : tmoc_properties

bind tmoc_top tmoc_properties #(.NUM(NUM)) u_props (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
  .COUNT_TICK_O(COUNT_TICK_O), .TRIGGER_O(TRIGGER_O), .RUNNING_O(RUNNING_O), .SLAVE_O(SLAVE_O),
  .MODE_O(MODE_O), .TIMER_OUT_O(TIMER_OUT_O));

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import tmoc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] ext_pin = 2'h0;
  logic [7:0] pulse = 8'h00;
  logic [7:0] r, p;
  logic pready, pslverr;
  logic [31:0] prdata;
  logic [7:0] timer_out;
  logic [1:0] tick, trigger, running, slave;
  logic [15:0] mode;
  logic [9:0] note;
  logic [9:0] notes [$];
  logic [31:0] lfsr = 32'h00012f5d;
  int fail_count, checks_done, t;
  int trig_cnt [2];
  int tick_cnt [2];

  tmoc_top dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready), .PRDATA_O(prdata),
    .PSLVERR_O(pslverr), .EXT_PIN_I(ext_pin), .PULSE_I(pulse), .TIMER_OUT_O(timer_out),
    .COUNT_TICK_O(tick), .TRIGGER_O(trigger), .RUNNING_O(running), .SLAVE_O(slave), .MODE_O(mode));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [7:0] rand8();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rand8

  function automatic logic [3:0] pin_exp(input logic [7:0] ctl, input logic [3:0] pl, input logic run);
    logic [3:0] e;
    for (int m = 0; m < 4; m++) begin
      e[m] = ctl[2*m] ? (pl[m] & run) ^ ctl[2*m+1] : ctl[2*m+1];
    end
    return e;
  endfunction : pin_exp

  // The note is queued before the request so the monitor never meets an empty queue.
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [7:0] wd, input logic [3:0] st,
                     input logic [7:0] ex, input logic err);
    notes.push_back({~wr, err, ex});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[29:0], 2'h0};
    pwdata <= {24'h000000, wd};
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    // The wait has no limit of its own; the watchdog ends it, so a silent slave still reaches the verdict.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'h1, 8'h00, 1'b0);
  endtask : wr

  task automatic rd(input logic [31:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, 4'h1, e, 1'b0);
  endtask : rd

  always @(posedge clk) begin
    for (int n = 0; n < 2; n++) begin
      trig_cnt[n] += trigger[n];
      tick_cnt[n] += tick[n];
    end
    if (pready === 1'b1) begin
      note = notes.pop_front();
      check("slverr", {31'h0, pslverr}, {31'h0, note[8]});
      if (note[9]) check("prdata", prdata, {24'h000000, note[7:0]});
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 2; n++) begin
      rd(TMOC_MODE_IDX[n], 8'h00);
      rd(TMOC_OUT_IDX[n], 8'h00);
      for (int c = 0; c < 8; c++) begin
        wr(TMOC_MODE_IDX[n], {n[0] & (c == 5), 7'h78} | 8'(c));
        rd(TMOC_MODE_IDX[n], {n[0] & (c == 5), 7'h20} | 8'(c));
        check("mode", {29'h0, mode[8*n+:3]}, 32'(c));
        check("slave", {31'h0, slave[n]}, 32'(n == 1 && c == 5));
      end
    end
    apb(1'b1, TMOC_MODE_IDX[0], 8'h00, 4'h0, 8'h00, 1'b0);
    rd(TMOC_MODE_IDX[0], 8'h27);
    apb(1'b0, 32'h00000003, 8'h00, 4'h1, 8'h00, 1'b1);
    for (int n = 0; n < 2; n++) begin
      for (int c = 0; c < 8; c++) begin
        wr(TMOC_RUN_IDX[n], 8'h00);
        wr(TMOC_MODE_IDX[n], 8'(c));
        wr(TMOC_RUN_IDX[n], 8'h80);
        t = trig_cnt[n];
        wr(TMOC_MODE_IDX[n], 8'h40 | 8'(c));
        repeat (3) @(posedge clk);
        #1;
        check("trigger", 32'(trig_cnt[n] - t), 32'(c == 2 || c == 3));
        rd(TMOC_MODE_IDX[n], 8'(c));
      end
    end
    wr(TMOC_RUN_IDX[0], 8'h00);
    wr(TMOC_MODE_IDX[0], 8'h05);
    // A window of 256 cycles holds a whole number of periods for every prescaler setting.
    for (int k = 0; k < 8; k++) begin
      wr(TMOC_RUN_IDX[0], 8'h00);
      wr(TMOC_RUN_IDX[0], 8'h80 | 8'(k));
      repeat (2) @(posedge clk);
      #1;
      check("running", {31'h0, running[0]}, 32'h1);
      repeat (8) @(posedge clk);
      #1;
      t = tick_cnt[0];
      repeat (256) @(posedge clk);
      #1;
      check("ticks", 32'(tick_cnt[0] - t), 32'(256 >> k));
    end
    wr(TMOC_RUN_IDX[0], 8'h00);
    wr(TMOC_RUN_IDX[0], 8'h82);
    wr(TMOC_RUN_IDX[1], 8'h00);
    wr(TMOC_MODE_IDX[1], 8'ha5);
    wr(TMOC_RUN_IDX[1], 8'h80);
    repeat (8) @(posedge clk);
    #1;
    t = tick_cnt[1];
    repeat (64) @(posedge clk);
    #1;
    check("slave ticks", 32'(tick_cnt[1] - t), 32'h10);
    rd(TMOC_STAT_IDX[1], 8'h03);
    for (int e = 0; e < 4; e++) begin
      wr(TMOC_RUN_IDX[0], 8'h00);
      wr(TMOC_MODE_IDX[0], 8'h25);
      wr(TMOC_EDGE_IDX[0], 8'(e << 2));
      wr(TMOC_RUN_IDX[0], 8'h80);
      repeat (8) @(posedge clk);
      #1;
      t = tick_cnt[0];
      for (int i = 0; i < 4; i++) begin
        @(posedge clk);
        ext_pin[0] <= ~ext_pin[0];
        repeat (4) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      #1;
      check("edges", 32'(tick_cnt[0] - t), e == 0 ? 32'h0 : e == 3 ? 32'h4 : 32'h2);
    end
    wr(TMOC_RUN_IDX[0], 8'h00);
    wr(TMOC_MODE_IDX[0], 8'h02);
    wr(TMOC_EDGE_IDX[0], 8'h01);
    wr(TMOC_RUN_IDX[0], 8'h80);
    repeat (4) @(posedge clk);
    #1;
    t = trig_cnt[0];
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      ext_pin[0] <= ~ext_pin[0];
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1;
    check("ext trigger", 32'(trig_cnt[0] - t), 32'h1);
    for (int n = 0; n < 2; n++) begin
      wr(TMOC_RUN_IDX[n], 8'h00);
      r = rand8();
      wr(TMOC_OUT_IDX[n], r);
      rd(TMOC_OUT_IDX[n], r);
      wr(TMOC_RUN_IDX[n], 8'h80);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 24; i++) begin
        @(posedge clk);
        p = pulse;
        pulse <= rand8();
        #1;
        check("pins", {28'h0, timer_out[4*n+:4]}, {28'h0, pin_exp(r, p[4*n+:4], 1'b1)});
      end
      wr(TMOC_RUN_IDX[n], 8'h00);
      repeat (4) @(posedge clk);
      #1;
      check("idle pins", {28'h0, timer_out[4*n+:4]}, {28'h0, pin_exp(r, pulse[4*n+:4], 1'b0)});
      check("stopped", {31'h0, running[n]}, 32'h0);
    end
    print_verdict();
  end
endmodule : tb
